// *** dv/isacs_link_master.sv ***
`timescale 1ns/1ps
module isacs_link_master (
  input wire logic scl,
  input wire logic sda,
  output logic scl_pull,
  output logic sda_pull
);
  initial begin
    scl_pull = 1'b0;
    sda_pull = 1'b0;
  end
  // Line changes land on odd ten-nanosecond marks, clear of both edges of
  // the bench clock, so no synchroniser sample races them.
  task automatic align();
    if ($time % 20 != 10) #((30 - $time % 20) % 20);
  endtask : align
  // Releasing and then waiting lets a slave stretch pause us at any bit.
  task automatic high_phase();
    scl_pull = 1'b0;
    wait (scl === 1'b1);
    align();
  endtask : high_phase
  task automatic xfer(input logic [8:0] d, output logic [8:0] q);
    align();
    for (int i = 8; i >= 0; i--) begin
      #20 sda_pull = !d[i];
      #180 high_phase();
      #60 q[i] = sda;
      #60 scl_pull = 1'b1;
    end
  endtask : xfer
  task automatic start();
    align();
    #100 sda_pull = 1'b0;
    #100 high_phase();
    #100 sda_pull = 1'b1;
    #100 scl_pull = 1'b1;
  endtask : start
  task automatic stop();
    align();
    #20 sda_pull = 1'b1;
    #180 high_phase();
    #100 sda_pull = 1'b0;
    #200;
  endtask : stop
endmodule : isacs_link_master

// *** dv/isacs_slave_chk.sv ***
`timescale 1ns/1ps
module isacs_slave_chk
  import isacs_pkg::*;
(
  input wire logic CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [APB_AW-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic SCL_IN,
  input wire logic SCL_OUT,
  input wire logic SCL_OE_N,
  input wire logic SDA_IN,
  input wire logic SDA_OUT,
  input wire logic SDA_OE_N,
  input wire logic SLV_EVENT
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  ////////////////////////////////////////////////////////////////////////////
  property p_rdy_one; PREADY |=> !PREADY; endproperty
  a_rdy_one: assert property (p_rdy_one) else $error("ready too long");
  property p_rdy_due; PSEL && PENABLE && !PREADY |=> PREADY; endproperty
  a_rdy_due: assert property (p_rdy_due) else $error("ready late");
  property p_err; PSLVERR |-> PREADY && PRDATA == 32'h0; endproperty
  a_err: assert property (p_err) else $error("bad error reply");
  property p_upper; PREADY |-> PRDATA[31:10] == 22'h0; endproperty
  a_upper: assert property (p_upper) else $error("upper bits set");
  property p_evt; SLV_EVENT |=> !SLV_EVENT; endproperty
  a_evt: assert property (p_evt) else $error("event too long");
  property p_evt_low; SLV_EVENT |-> !SCL_IN; endproperty
  a_evt_low: assert property (p_evt_low) else $error("event off fall");
  // Data and ack may only move while the clock is low.
  property p_sda_chg; $changed(SDA_OE_N) |-> !SCL_IN; endproperty
  a_sda_chg: assert property (p_sda_chg) else $error("sda moved");
  property p_hold; $fell(SCL_OE_N) |-> !SCL_IN && !SCL_OUT; endproperty
  a_hold: assert property (p_hold) else $error("bad hold");
  property p_rel;
    $rose(SCL_OE_N) |-> $past(PREADY, 2) && $past(PWRITE, 2) &&
      $past(PADDR, 2) == OFF_CTRL;
  endproperty
  a_rel: assert property (p_rel) else $error("release w/o write");
  c_evt: cover property (SLV_EVENT);
  c_hold: cover property ($fell(SCL_OE_N));
  c_err: cover property (PSLVERR);
endmodule : isacs_slave_chk

bind isacs_slave isacs_slave_chk u_chk (
  .CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
  .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
  .PSLVERR(PSLVERR), .SCL_IN(SCL_IN), .SCL_OUT(SCL_OUT),
  .SCL_OE_N(SCL_OE_N), .SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT),
  .SDA_OE_N(SDA_OE_N), .SLV_EVENT(SLV_EVENT)
);

// *** dv/test_isacs_slave.sv ***
`timescale 1ns/1ps
module test_isacs_slave
  import isacs_pkg::*;
;
  logic clk, rst, psel, penable, pwrite, err, m_scl, m_sda;
  logic [APB_AW-1:0] paddr;
  logic [31:0] pwdata, prdata, rd, ctl;
  logic pready, pslverr, scl_oe_n, sda_oe_n, scl_out, sda_out, slv_event;
  logic [8:0] q;
  int n_fail, checks_done, n_evt, e;
  wire scl = !(m_scl === 1'b1 || scl_oe_n === 1'b0);
  wire sda = !(m_sda === 1'b1 || sda_oe_n === 1'b0);
  isacs_slave dut (
    .CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .SCL_IN(scl), .SCL_OUT(scl_out),
    .SCL_OE_N(scl_oe_n), .SDA_IN(sda), .SDA_OUT(sda_out),
    .SDA_OE_N(sda_oe_n), .SLV_EVENT(slv_event)
  );
  isacs_link_master mst (
    .scl(scl), .sda(sda), .scl_pull(m_scl), .sda_pull(m_sda)
  );
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) if (slv_event === 1'b1) n_evt <= n_evt + 1;
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string w, input logic [31:0] x, y);
    checks_done++;
    if (y !== x) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", w, x, y);
    end
  endtask : check
  task automatic apb(input logic wr, input logic [7:0] a, input [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rdchk(string w, logic [7:0] a, logic [31:0] m, x);
    apb(1'b0, a, 32'h0);
    check(w, x, rd & m);
  endtask : rdchk
  task automatic hold_rel(input logic [7:0] a, input logic [31:0] d);
    repeat (8) @(posedge clk);
    check("scl held", 32'h0, {31'h0, scl_oe_n});
    apb(1'b1, a, d);
    apb(1'b1, OFF_CTRL, ctl);
  endtask : hold_rel
  task automatic miss(input logic [31:0] own, input logic [7:0] b);
    apb(1'b1, OFF_ADDR, own);
    mst.start();
    mst.xfer({b, 1'b1}, q);
    check("nack", 32'h1, {31'h0, q[0]});
    mst.stop();
  endtask : miss
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    rdchk("ctrl rst", OFF_CTRL, 32'hf, {28'h0, CTRL_RST});
    rdchk("addr rst", OFF_ADDR, 32'h3ff, {22'h0, ADDR_RST});
    rdchk("stat rst", OFF_STAT, 32'h7f, 32'h0);
    check("pins low", 32'h0, {30'h0, scl_out, sda_out});
    apb(1'b0, 8'h14, 32'h0);
    check("unmapped", 32'h1, {31'h0, err});
    apb(1'b1, OFF_CTRL, 32'h1);
    rdchk("release kept", OFF_CTRL, 32'hf, 32'h9);
    $display("t_regs done");
  endtask : t_regs
  task automatic t_rx7();
    ctl = 32'hd;
    apb(1'b1, OFF_ADDR, 32'h352);
    apb(1'b1, OFF_CTRL, ctl);
    e = n_evt;
    mst.start();
    mst.xfer({8'ha4, 1'b1}, q);
    check("addr ack", 32'h0, {31'h0, q[0]});
    rdchk("rbf addr", OFF_STAT, 32'h1, 32'h0);
    mst.xfer({8'ha5, 1'b1}, q);
    check("ack 1", 32'h0, {31'h0, q[0]});
    hold_rel(OFF_CTRL, ctl);
    mst.xfer({8'h3c, 1'b1}, q);
    check("nack full", 32'h1, {31'h0, q[0]});
    hold_rel(OFF_CTRL, ctl);
    rdchk("kept byte", OFF_RXB, 32'hff, 32'ha5);
    mst.xfer({8'h77, 1'b1}, q);
    check("nack ovf", 32'h1, {31'h0, q[0]});
    hold_rel(OFF_CTRL, ctl);
    rdchk("ovf byte", OFF_RXB, 32'hff, 32'h77);
    fork
      mst.xfer({8'h5c, 1'b1}, q);
      #2700 rdchk("early read", OFF_RXB, 32'hff, 32'h5c);
    join
    repeat (8) @(posedge clk);
    check("no rx stretch", 32'h1, {31'h0, scl_oe_n});
    apb(1'b1, OFF_CTRL, 32'h5);
    hold_rel(OFF_CTRL, ctl);
    mst.stop();
    check("rx events", e + 5, n_evt);
    apb(1'b1, OFF_STAT, 32'h12);
    rdchk("ovf clear", OFF_STAT, 32'h2, 32'h0);
    e = n_evt;
    miss(32'h3, 8'h06);
    miss(32'h78, 8'hf0);
    miss(32'h352, 8'ha6);
    check("miss events", e, n_evt);
    $display("t_rx7 done");
  endtask : t_rx7
  task automatic t_tx7();
    apb(1'b1, OFF_ADDR, 32'h352);
    e = n_evt;
    mst.start();
    mst.xfer({8'ha5, 1'b1}, q);
    check("rd ack", 32'h0, {31'h0, q[0]});
    hold_rel(OFF_TXH, 32'hc3);
    fork
      mst.xfer({8'hff, 1'b0}, q);
      #2600 apb(1'b1, OFF_TXH, 32'h5a);
    join
    check("tx 1", 32'hc3, {24'h0, q[8:1]});
    repeat (8) @(posedge clk);
    check("no stretch", 32'h1, {31'h0, scl_oe_n});
    mst.xfer({8'hff, 1'b1}, q);
    check("tx 2", 32'h5a, {24'h0, q[8:1]});
    repeat (8) @(posedge clk);
    check("nack no hold", 32'h1, {31'h0, scl_oe_n});
    apb(1'b1, OFF_CTRL, ctl);
    mst.stop();
    check("tx events", e + 3, n_evt);
    $display("t_tx7 done");
  endtask : t_tx7
  task automatic t_ten();
    ctl = 32'hf;
    apb(1'b1, OFF_ADDR, 32'h2b7);
    apb(1'b1, OFF_CTRL, ctl);
    e = n_evt;
    mst.start();
    mst.xfer({8'hf4, 1'b1}, q);
    check("hi ack", 32'h0, {31'h0, q[0]});
    hold_rel(OFF_CTRL, ctl);
    mst.xfer({8'hb7, 1'b1}, q);
    check("lo ack", 32'h0, {31'h0, q[0]});
    rdchk("full match", OFF_STAT, 32'h8, 32'h8);
    hold_rel(OFF_CTRL, ctl);
    mst.start();
    mst.xfer({8'hf5, 1'b1}, q);
    check("rs ack", 32'h0, {31'h0, q[0]});
    hold_rel(OFF_TXH, 32'h96);
    mst.xfer({8'hff, 1'b1}, q);
    check("ten tx", 32'h96, {24'h0, q[8:1]});
    apb(1'b1, OFF_CTRL, ctl);
    mst.stop();
    check("ten events", e + 4, n_evt);
    $display("t_ten done");
  endtask : t_ten
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_of_test
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_rx7();
    t_tx7();
    t_ten();
    end_of_test();
  end
  // About fifteen bytes of link traffic fit well inside this span.
  initial begin
    #2000000;
    n_fail++;
    end_of_test();
  end
endmodule : test_isacs_slave

// *** rtl/isacs_slave.sv ***
// Chosen here: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
// Summary of operation
// R1: Seven-bit mode compares only the low seven own-address bits.
// R2: Ten-bit mode compares first byte with 11110 plus address bits 9:8.
// R3: After first byte matches, second byte compares with address bits 7:0.
// R4: Seven-bit addresses split into call, reserved, Hs, normal, ten-bit prefix.
// R5: Enabled slave idles until Start, then shifts eight address bits.
// R6: Address 6:0 versus shift bits 7:1; bit 0 is direction; sample on rise.
// R7: Match acks and flags event at ninth fall; receive buffer untouched.
// R8: Read address enters transmit, holds SCL until data and release set.
// R9: Transmit event pulse at ninth fall whatever the master answered.
// R10: Write address receives; byte moves to buffer if not full, acked.
// R11: Buffer still full: no ack, no load, event pulse still given.
// R12: Overflow set but buffer empty: load buffer yet answer not-ack.
// R13: Ten-bit first byte match with write pulses event, clears full match.
// R14: Low byte match pulses event, sets full match; mismatch returns idle.
// R15: Repeated Start with high byte and read after full match starts transmit.
// R16: Transmit with empty buffer at ninth fall clears release, holds SCL.
// R17: Buffer loaded before ninth fall means no stretch; release settable always.
// R18: Receive with stretch enable and full buffer at ninth fall stretches.
// R19: Buffer read before ninth fall leaves release set, no stretch.
// R20: Ten-bit addressing stretches during address bytes, then per data byte.
// R21: Software release clear holds SCL only after a seen fall, SCL low.
// R22: Stretch enable clear makes software clears of release ineffective.
// R23: Shift register and buffer double-buffer receive; holding register and shifter double-buffer transmit.
// R24: After Repeated Start in ten-bit mode only the first byte must match.
// R25: SCL and SDA pass a two-stage synchroniser before any use.
module isacs_slave
  import isacs_pkg::*;
(
  input wire logic CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [APB_AW-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic SCL_IN,
  output logic SCL_OUT,
  output logic SCL_OE_N,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE_N,
  output logic SLV_EVENT
);

  function automatic isacs_acls_e addr_class(input logic [6:0] a);
    if (a == GEN_CALL) return AC_GCALL;
    if (a <= RSV_LO_END) return AC_RSVD;
    if (a <= HS_END) return AC_HS;
    if (a <= NORM_END) return AC_NORMAL;
    if (a <= TEN_END) return AC_TENPFX;
    return AC_RSVD;
  endfunction : addr_class

  //////////////////////////////////////////////////////////////////////////
  logic scl_m, scl_s, scl_d, sda_m, sda_s, sda_d;
  logic fall_seen;
  isacs_ctrl_s ctrl;
  logic [OWN_AW-1:0] own_slave_address;
  logic [7:0] rx_shift_reg, rx_buffer, tx_holding_reg, tx_sr;
  logic rx_buffer_full, rx_overflow, tx_buffer_full;
  logic full_ten_bit_match, slave_event_flag, addressed_state, dir_read;
  logic [3:0] cnt;
  isacs_state_e state, nxt_state;
  logic ack_drv, evt_pend, stretch_pend, tx_need, tx_on, mack;
  logic pready, pslverr, scl_oe_n, sda_oe_n, slv_event;
  logic [31:0] prdata;

  // Bus levels are asynchronous, so only the second and third stages are ever read.
  always_ff @(posedge CLK) begin
    if (RST) begin
      {scl_m, scl_s, scl_d} <= 3'h7;
      {sda_m, sda_s, sda_d} <= 3'h7;
    end else begin
      {scl_m, scl_s, scl_d} <= {SCL_IN, scl_m, scl_s}; // [R25]
      {sda_m, sda_s, sda_d} <= {SDA_IN, sda_m, sda_s}; // [R25]
    end
  end

  wire scl_rise = scl_s & ~scl_d;
  wire scl_fall = ~scl_s & scl_d;
  wire start_det = scl_s & scl_d & sda_d & ~sda_s;
  wire stop_det = scl_s & scl_d & ~sda_d & sda_s;
  wire active = (state != S_IDLE) && (state != S_WAIT);
  wire byte_end = active & scl_fall & (cnt == BYTE_BITS);
  wire ninth_fall = active & scl_fall & (cnt == NINTH);

  //////////////////////////////////////////////////////////////////////////
  wire own7_ok = addr_class(own_slave_address[6:0]) == AC_NORMAL; // [R4]
  wire match7 = own7_ok &&
    (rx_shift_reg[7:1] == own_slave_address[6:0]); // [R1] [R6]
  wire match_hi = (rx_shift_reg[7:3] == TEN_PREFIX) &&
    (rx_shift_reg[2:1] == own_slave_address[9:8]); // [R2] [R13]
  wire match_lo = rx_shift_reg == own_slave_address[7:0]; // [R3] [R14]

  logic dec_ack, dec_evt, dec_load, dec_stretch;
  isacs_state_e dec_next;
  always_comb begin
    dec_ack = 1'b0;
    dec_evt = 1'b0;
    dec_load = 1'b0;
    dec_stretch = 1'b0;
    dec_next = S_WAIT;
    case (state)
      S_ADDR1: begin
        if (!ctrl.ten_bit_addr_mode) begin
          if (match7) begin // [R7]
            dec_ack = 1'b1;
            dec_evt = 1'b1;
            dec_next = rx_shift_reg[0] ? S_TX : S_RX; // [R8] [R10]
          end
        end else if (match_hi && !rx_shift_reg[0]) begin // [R13]
          dec_ack = 1'b1;
          dec_evt = 1'b1;
          dec_stretch = ctrl.stretch_enable; // [R20]
          dec_next = S_ADDR2;
        end else if (match_hi && addressed_state) begin // [R15] [R24]
          dec_ack = 1'b1;
          dec_evt = 1'b1;
          dec_next = S_TX;
        end
      end
      S_ADDR2: begin
        if (match_lo) begin // [R14]
          dec_ack = 1'b1;
          dec_evt = 1'b1;
          dec_stretch = ctrl.stretch_enable; // [R20]
          dec_next = S_RX;
        end
      end
      S_RX: begin
        dec_evt = 1'b1; // [R11]
        dec_next = S_RX;
        if (!rx_buffer_full) begin
          dec_load = 1'b1; // [R10] [R12]
          dec_ack = !rx_overflow; // [R12]
        end
      end
      default: begin
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  wire acc = PSEL & PENABLE;
  wire done = acc & pready;
  wire wr = done & PWRITE;
  wire rd = done & ~PWRITE;
  wire hit_ctrl = PADDR == OFF_CTRL;
  wire hit_stat = PADDR == OFF_STAT;
  wire hit_addr = PADDR == OFF_ADDR;
  wire hit_rxb = PADDR == OFF_RXB;
  wire hit_txh = PADDR == OFF_TXH;
  wire mapped = hit_ctrl | hit_stat | hit_addr | hit_rxb | hit_txh;
  wire isacs_ctrl_s wctrl = PWDATA[3:0];
  wire isacs_stat_s stat = {~scl_oe_n, dir_read, slave_event_flag,
    full_ten_bit_match, tx_buffer_full, rx_overflow, rx_buffer_full};
  wire [31:0] rdmux = hit_ctrl ? {28'h0, ctrl} :
    hit_stat ? {25'h0, stat} :
    hit_addr ? {22'h0, own_slave_address} :
    hit_rxb ? {24'h0, rx_buffer} :
    hit_txh ? {24'h0, tx_holding_reg} : 32'h0;

  // One wait state keeps every answer signal on a flip-flop.
  always_ff @(posedge CLK) begin
    if (RST) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= acc & ~pready;
      pslverr <= acc & ~pready & ~mapped;
      prdata <= (acc & ~pready) ? rdmux : prdata;
    end
  end

  // Writing zero to release only counts while stretching is enabled.
  wire sw_rel_wr = wr & hit_ctrl;
  wire sw_rel_set = sw_rel_wr & wctrl.clock_release; // [R17]
  wire sw_rel_clr = sw_rel_wr & ~wctrl.clock_release &
    ctrl.stretch_enable; // [R22]
  // A master that answers not-acknowledge ends the read, so no stretch.
  wire tx_stall = (nxt_state == S_TX) & ~tx_buffer_full &
    ~mack; // [R8] [R16]
  wire rx_stall = (state == S_RX) & ctrl.stretch_enable &
    rx_buffer_full; // [R18] [R19]
  wire auto_clr = ninth_fall & (tx_stall | rx_stall | stretch_pend);
  wire tx_load = (state == S_TX) & tx_need & tx_buffer_full;

  always_ff @(posedge CLK) begin
    if (RST) begin
      ctrl <= CTRL_RST;
      own_slave_address <= ADDR_RST;
    end else begin
      if (sw_rel_wr) begin
        ctrl.module_enable <= wctrl.module_enable;
        ctrl.ten_bit_addr_mode <= wctrl.ten_bit_addr_mode;
        ctrl.stretch_enable <= wctrl.stretch_enable;
      end
      if (sw_rel_set) begin
        ctrl.clock_release <= 1'b1; // [R17]
      end else if (auto_clr | sw_rel_clr) begin
        ctrl.clock_release <= 1'b0; // [R16] [R18] [R20] [R22]
      end
      if (wr & hit_addr) begin
        own_slave_address <= PWDATA[OWN_AW-1:0];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Hardware sets win over software clears in the flags below.
  wire load_now = byte_end & dec_load;
  wire ovf_now = byte_end & (state == S_RX) & rx_buffer_full; // [R11]
  always_ff @(posedge CLK) begin
    if (RST) begin
      rx_buffer <= 8'h0;
      rx_buffer_full <= 1'b0;
      rx_overflow <= 1'b0;
      tx_holding_reg <= 8'h0;
      tx_buffer_full <= 1'b0;
      slave_event_flag <= 1'b0;
    end else begin
      if (load_now) begin
        rx_buffer <= rx_shift_reg; // [R23]
      end
      rx_buffer_full <= load_now |
        (rx_buffer_full & ~(rd & hit_rxb)); // [R19]
      rx_overflow <= ovf_now |
        (rx_overflow & ~(wr & hit_stat & PWDATA[ST_OV]));
      if (wr & hit_txh) begin
        tx_holding_reg <= PWDATA[7:0];
      end
      tx_buffer_full <= (wr & hit_txh) |
        (tx_buffer_full & ~tx_load); // [R17]
      slave_event_flag <= (ninth_fall & evt_pend) |
        (slave_event_flag & ~(wr & hit_stat & PWDATA[ST_EVT])); // [R7]
    end
  end

  //////////////////////////////////////////////////////////////////////////
  always_ff @(posedge CLK) begin
    if (RST) begin
      state <= S_IDLE;
      nxt_state <= S_IDLE;
      cnt <= 4'h0;
      rx_shift_reg <= 8'h0;
      ack_drv <= 1'b0;
      evt_pend <= 1'b0;
      stretch_pend <= 1'b0;
      full_ten_bit_match <= 1'b0;
      addressed_state <= 1'b0;
      dir_read <= 1'b0;
      mack <= 1'b0;
    end else if (!ctrl.module_enable || stop_det) begin
      state <= S_IDLE;
      ack_drv <= 1'b0;
      evt_pend <= 1'b0;
      stretch_pend <= 1'b0;
      addressed_state <= 1'b0;
    end else if (start_det) begin
      state <= S_ADDR1; // [R5]
      cnt <= 4'h0;
      ack_drv <= 1'b0;
      evt_pend <= 1'b0;
      stretch_pend <= 1'b0;
    end else if (active) begin
      if (scl_rise && cnt != NINTH) begin
        cnt <= cnt + 4'h1;
      end
      if (scl_rise && cnt < BYTE_BITS) begin
        rx_shift_reg <= {rx_shift_reg[6:0], sda_s}; // [R5] [R6]
      end
      if (scl_rise && cnt == BYTE_BITS) begin
        mack <= sda_s;
      end
      if (byte_end && state != S_TX) begin
        ack_drv <= dec_ack; // [R7] [R10] [R11] [R12]
        evt_pend <= dec_evt;
        stretch_pend <= dec_stretch;
        nxt_state <= dec_next;
        if (state == S_ADDR1) begin
          dir_read <= rx_shift_reg[0];
        end
        if (state == S_ADDR1 && ctrl.ten_bit_addr_mode) begin
          full_ten_bit_match <= 1'b0; // [R13]
        end
        if (state == S_ADDR2) begin
          full_ten_bit_match <= match_lo; // [R14]
          addressed_state <= match_lo; // [R24]
        end
      end
      if (byte_end && state == S_TX) begin
        evt_pend <= 1'b1; // [R9]
        stretch_pend <= 1'b0;
        nxt_state <= S_TX;
      end
      if (ninth_fall) begin
        cnt <= 4'h0;
        ack_drv <= 1'b0;
        evt_pend <= 1'b0;
        state <= (state == S_TX && mack) ? S_WAIT : nxt_state;
      end
    end
  end

  // Transmit path has one holding register; the shifter reloads from it.
  always_ff @(posedge CLK) begin
    if (RST) begin
      tx_sr <= 8'h0;
      tx_need <= 1'b0;
      tx_on <= 1'b0;
    end else if (state != S_TX || start_det || stop_det) begin
      tx_need <= ninth_fall & (nxt_state == S_TX); // [R8] [R15]
      tx_on <= 1'b0;
    end else if (tx_load) begin
      tx_sr <= tx_holding_reg; // [R23]
      tx_need <= 1'b0;
      tx_on <= 1'b1;
    end else if (byte_end) begin
      tx_on <= 1'b0;
    end else if (ninth_fall) begin
      tx_need <= ~mack;
    end else if (scl_fall && tx_on && cnt != 4'h0) begin
      tx_sr <= {tx_sr[6:0], 1'b0}; // [R8]
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // A cleared release only pulls SCL after a fall has been seen and SCL
  // reads low, so a stretch never shortens a high phase.
  wire next_hold = ~ctrl.clock_release & ~scl_s &
    (~scl_oe_n | fall_seen | scl_fall); // [R21]
  always_ff @(posedge CLK) begin
    if (RST) begin
      fall_seen <= 1'b0;
      scl_oe_n <= 1'b1;
      sda_oe_n <= 1'b1;
      slv_event <= 1'b0;
      SCL_OUT <= 1'b0;
      SDA_OUT <= 1'b0;
    end else begin
      fall_seen <= scl_fall | (fall_seen & ~scl_rise);
      scl_oe_n <= ~next_hold; // [R16] [R18] [R21]
      sda_oe_n <= ~(ack_drv | (tx_on & ~tx_sr[7]));
      slv_event <= ninth_fall & evt_pend; // [R7] [R9] [R11]
      SCL_OUT <= 1'b0;
      SDA_OUT <= 1'b0;
    end
  end

  assign PREADY = pready;
  assign PSLVERR = pslverr;
  assign PRDATA = prdata;
  assign SCL_OE_N = scl_oe_n;
  assign SDA_OE_N = sda_oe_n;
  assign SLV_EVENT = slv_event;

endmodule : isacs_slave

// *** shared/isacs_pkg.sv ***
package isacs_pkg;

  localparam int unsigned APB_AW = 8;
  localparam logic [APB_AW-1:0] OFF_CTRL = 8'h00;
  localparam logic [APB_AW-1:0] OFF_STAT = 8'h04;
  localparam logic [APB_AW-1:0] OFF_ADDR = 8'h08;
  localparam logic [APB_AW-1:0] OFF_RXB = 8'h0c;
  localparam logic [APB_AW-1:0] OFF_TXH = 8'h10;

  localparam int unsigned OWN_AW = 10;
  localparam logic [OWN_AW-1:0] ADDR_RST = 10'h000;

  // Control register, bits 3:0.
  typedef struct packed {
    logic clock_release;
    logic stretch_enable;
    logic ten_bit_addr_mode;
    logic module_enable;
  } isacs_ctrl_s;
  localparam isacs_ctrl_s CTRL_RST = 4'h8;

  // Status register, bits 6:0.
  typedef struct packed {
    logic scl_held;
    logic dir_read;
    logic slave_event_flag;
    logic full_ten_bit_match;
    logic tx_buffer_full;
    logic rx_overflow;
    logic rx_buffer_full;
  } isacs_stat_s;
  localparam int unsigned ST_OV = 1;
  localparam int unsigned ST_EVT = 4;

  localparam logic [4:0] TEN_PREFIX = 5'h1e;
  localparam logic [6:0] GEN_CALL = 7'h00;
  localparam logic [6:0] RSV_LO_END = 7'h03;
  localparam logic [6:0] HS_END = 7'h07;
  localparam logic [6:0] NORM_END = 7'h77;
  localparam logic [6:0] TEN_END = 7'h7b;

  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] NINTH = 4'h9;

  typedef enum logic [2:0] {
    AC_GCALL,
    AC_RSVD,
    AC_HS,
    AC_NORMAL,
    AC_TENPFX
  } isacs_acls_e;

  typedef enum {
    S_IDLE,
    S_ADDR1,
    S_ADDR2,
    S_RX,
    S_TX,
    S_WAIT
  } isacs_state_e;

endpackage : isacs_pkg
